// [rtl/fpr_pkg.sv]
// Shared offsets, fields, reset values and sizing functions
package fpr_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_MAC_CTRL = 8'h60;
  localparam logic [7:0] OFS_ERR_STAT = 8'h64;
  localparam logic [7:0] OFS_LEVELS = 8'h6C;
  localparam logic [7:0] OFS_HARDWARE_CONFIG = 8'h74;
  localparam logic [7:0] OFS_RX_PATH = 8'h78;
  // Field positions
  localparam int HC_SOFT_RST = 0;
  localparam int HC_SOFT_TO = 1;
  localparam int HC_SIZE_LO = 16;
  localparam int HC_MBO = 20;
  localparam int HC_KEEP_LO = 28;
  localparam int RP_SKIP = 31;
  localparam int ES_TX_ERR = 0;
  localparam int ES_RX_ERR = 1;
  localparam int ES_DROP_LO = 16;
  localparam int MC_RX_EN = 0;
  // Values after reset and the legal size range
  localparam logic [31:0] MAC_CTRL_RST = 32'h0000_0000;
  localparam logic [3:0] SIZE_RST = 4'h5;
  localparam logic [3:0] SIZE_MIN = 4'h2;
  localparam logic [3:0] SIZE_MAX = 4'hE;
  // Memory split
  localparam int TOTAL_BYTES = 16384;
  localparam int TX_STAT_BYTES = 512;
  localparam int RX_STAT_SHIFT = 4;
  localparam logic [12:0] TOTAL_WORDS = 13'(TOTAL_BYTES / 4);
  localparam logic [12:0] TX_STAT_WORDS = 13'(TX_STAT_BYTES / 4);
  localparam logic [12:0] RX_FULL_MARGIN = 13'h0004;
  localparam int MIL_TX_BYTES = 2048;
  localparam int MIL_RX_BYTES = 128;
  localparam logic [9:0] MIL_TX_WORDS = 10'(MIL_TX_BYTES / 4);
  localparam logic [6:0] MIL_RX_WORDS = 7'(MIL_RX_BYTES / 4);
  localparam logic [1:0] MIL_TX_FRAMES = 2'h2;
  localparam int TX_LEN_DEPTH = 128;
  localparam int RX_LEN_DEPTH = 256;
  // Soft reset wait for the PHY clocks
  localparam int CLK_PERIOD_NS = 25;
  localparam int SOFT_WAIT_NS = 10000;
  localparam int SOFT_WAIT_CYC = SOFT_WAIT_NS / CLK_PERIOD_NS;
  localparam logic [8:0] SOFT_CNT_LAST = 9'(SOFT_WAIT_CYC - 1);

  typedef enum logic [1:0] {
    SR_IDLE = 2'b00,
    SR_WAIT = 2'b01
  } fpr_soft_e;

  // Reserved size codes are pinned into the legal range
  function automatic logic [3:0] eff_size(input logic [3:0] s);
    if (s < SIZE_MIN) return SIZE_MIN;
    else if (s > SIZE_MAX) return SIZE_MAX;
    else return s;
  endfunction

  // Size code times 256 words is the kilobyte count in words
  function automatic logic [12:0] tx_data_words(input logic [3:0] s);
    return {1'b0, eff_size(s), 8'h00} - TX_STAT_WORDS;
  endfunction

  function automatic logic [12:0] rx_total_words(input logic [3:0] s);
    return TOTAL_WORDS - {1'b0, eff_size(s), 8'h00};
  endfunction

  function automatic logic [12:0] rx_stat_words(input logic [3:0] s);
    return rx_total_words(s) >> RX_STAT_SHIFT;
  endfunction

  function automatic logic [12:0] rx_data_words(input logic [3:0] s);
    return rx_total_words(s) - rx_stat_words(s);
  endfunction
endpackage

// [rtl/fpr_mil_rx.sv]
// MAC-side receive buffer with overrun frame dropping
`timescale 1ns/10ps
module fpr_mil_rx (
  input logic clk,
  input logic rst_n,
  input logic clr,
  input logic enable,
  input logic in_valid,
  input logic in_last,
  input logic out_ready,
  output logic out_valid,
  output logic out_last,
  output logic drop_pulse
);
  logic [5:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [5:0] sp_reg, sp_next, cp_reg, cp_next;
  logic [31:0] bits_reg, bits_next;
  logic drop_reg, drop_next, ovr_reg, ovr_next, full;
  logic [6:0] fill;

  // Only whole frames are offered downstream
  // Pointer difference stays six bits so it wraps with the pointers
  assign fill = {1'b0, wp_reg - rp_reg};
  assign full = fill == fpr_pkg::MIL_RX_WORDS;
  assign out_valid = rp_reg != cp_reg;
  assign out_last = bits_reg[rp_reg[4:0]];

  // Pointer and drop state update
  always_comb begin
    wp_next = wp_reg;
    rp_next = rp_reg;
    sp_next = sp_reg;
    cp_next = cp_reg;
    bits_next = bits_reg;
    drop_next = drop_reg;
    ovr_next = ovr_reg;
    drop_pulse = 1'b0;
    if (out_valid && out_ready) begin
      rp_next = rp_reg + 6'd1;
    end
    if (out_ready) begin
      ovr_next = 1'b0; // Room made downstream
    end
    if (in_valid) begin
      if (drop_reg) begin
        if (in_last) begin
          drop_next = 1'b0;
          drop_pulse = 1'b1;
        end
      end else if (!enable || full || (ovr_reg && wp_reg == sp_reg)) begin
        // Rewind over the partial frame so no torn frame leaks out
        wp_next = sp_reg;
        ovr_next = full || ovr_reg;
        if (in_last) begin
          drop_pulse = 1'b1;
        end else begin
          drop_next = 1'b1;
        end
      end else begin
        bits_next[wp_reg[4:0]] = in_last;
        wp_next = wp_reg + 6'd1;
        if (in_last) begin
          sp_next = wp_reg + 6'd1;
          cp_next = wp_reg + 6'd1;
        end
      end
    end
    if (clr) begin
      wp_next = '0;
      rp_next = '0;
      sp_next = '0;
      cp_next = '0;
      drop_next = 1'b0;
      ovr_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
      sp_reg <= '0;
      cp_reg <= '0;
      bits_reg <= '0;
      drop_reg <= 1'b0;
      ovr_reg <= 1'b0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      sp_reg <= sp_next;
      cp_reg <= cp_next;
      bits_reg <= bits_next;
      drop_reg <= drop_next;
      ovr_reg <= ovr_next;
    end
  end

  a_rx_fill_cap: assert property (
    @(posedge clk) disable iff (!rst_n) fill <= fpr_pkg::MIL_RX_WORDS)
    else $error("MAC-side receive buffer over capacity");
endmodule

// [rtl/fpr_mil_tx.sv]
// MAC-side transmit buffer holding at most two frames
`timescale 1ns/10ps
module fpr_mil_tx (
  input logic clk,
  input logic rst_n,
  input logic clr,
  input logic in_valid,
  input logic in_last,
  output logic in_ready,
  input logic mac_take,
  output logic out_valid,
  output logic out_last
);
  logic [9:0] cnt_reg, cnt_next;
  logic [8:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [1:0] frm_reg, frm_next;
  logic open_reg, open_next, put, take;
  logic last_mem [512];

  // Accept while words fit and no third frame would start
  assign in_ready = cnt_reg != fpr_pkg::MIL_TX_WORDS &&
                    (open_reg || frm_reg != fpr_pkg::MIL_TX_FRAMES);
  assign put = in_valid && in_ready;
  assign out_valid = cnt_reg != 10'd0;
  assign out_last = last_mem[rp_reg];
  assign take = out_valid && mac_take;

  always_comb begin
    cnt_next = cnt_reg + 10'(put) - 10'(take);
    wp_next = put ? wp_reg + 9'd1 : wp_reg;
    rp_next = take ? rp_reg + 9'd1 : rp_reg;
    open_next = put ? !in_last : open_reg;
    frm_next = frm_reg + 2'((put && !open_reg) ? 1 : 0)
               - 2'((take && out_last) ? 1 : 0);
    if (clr) begin
      cnt_next = '0;
      wp_next = '0;
      rp_next = '0;
      open_next = 1'b0;
      frm_next = '0;
    end
  end

  // End-of-frame marks need no reset; counters guard them
  always_ff @(posedge clk) begin
    if (put) begin
      last_mem[wp_reg] <= in_last;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      wp_reg <= '0;
      rp_reg <= '0;
      open_reg <= 1'b0;
      frm_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      open_reg <= open_next;
      frm_reg <= frm_next;
    end
  end

  a_tx_two_frames: assert property (
    @(posedge clk) disable iff (!rst_n)
    frm_reg <= fpr_pkg::MIL_TX_FRAMES && cnt_reg <= fpr_pkg::MIL_TX_WORDS)
    else $error("MAC-side transmit buffer holds too much");
endmodule

// [rtl/fpr_fifo_ctrl.sv]
// FIFO partition, soft reset and receive skip with APB registers
`timescale 1ns/10ps
module fpr_fifo_ctrl (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic phy_clk_ok,
  input logic pm_wake,
  input logic host_tx_push,
  input logic host_tx_last,
  input logic host_rx_pop,
  input logic mac_rx_valid,
  input logic mac_rx_last,
  input logic mac_tx_take,
  output logic mac_tx_valid,
  output logic mac_tx_last,
  output logic rx_frame_ready,
  output logic [31:0] mac_ctrl
);
  logic phy_meta_reg, phy_sync_reg;
  fpr_pkg::fpr_soft_e st_reg, st_next;
  logic [8:0] cnt_reg, cnt_next;
  logic [31:0] mac_reg, mac_next, rd_val, prdata_next;
  logic [3:0] size_reg, size_next;
  logic [1:0] keep_reg, keep_next;
  logic [15:0] drop_reg, drop_next;
  logic mbo_reg, mbo_next, to_reg, to_next, seen_reg, seen_next;
  logic txerr_reg, txerr_next, rxerr_reg, rxerr_next, skip_reg, skip_next;
  logic sreset, mapped, wr_ok, rd_acc, tx_err_ev, rx_err_ev, drop_pulse;
  logic [12:0] tx_cap, rx_cap, rx_scap;
  logic [12:0] tx_used_reg, tx_used_next, rx_used_reg, rx_used_next;
  logic [11:0] tx_wlen_reg, tx_wlen_next, tx_cons_reg, tx_cons_next;
  logic [11:0] rx_cur_reg, rx_cur_next, rx_cons_reg, rx_cons_next;
  logic [6:0] tx_wi_reg, tx_wi_next, tx_ri_reg, tx_ri_next;
  logic [7:0] tx_fc_reg, tx_fc_next, rx_wi_reg, rx_wi_next;
  logic [7:0] rx_ri_reg, rx_ri_next;
  logic [8:0] rx_sc_reg, rx_sc_next;
  logic tx_push, tx_move, tx_mv_last, mil_tx_rdy;
  logic rx_full, rx_room, rx_in, mil_rx_valid, mil_rx_last, rx_take, rx_head_end;
  logic [11:0] tx_len_mem [fpr_pkg::TX_LEN_DEPTH];
  logic [11:0] rx_len_mem [fpr_pkg::RX_LEN_DEPTH];

  // PHY clock status is a pin: two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_meta_reg <= 1'b0;
      phy_sync_reg <= 1'b0;
    end else begin
      phy_meta_reg <= phy_clk_ok;
      phy_sync_reg <= phy_meta_reg;
    end
  end

  // APB decode; zero wait states, unmapped offsets flag an error
  always_comb begin
    unique case (paddr)
      fpr_pkg::OFS_MAC_CTRL, fpr_pkg::OFS_ERR_STAT, fpr_pkg::OFS_LEVELS,
      fpr_pkg::OFS_HARDWARE_CONFIG, fpr_pkg::OFS_RX_PATH: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign rd_acc = psel && penable && !pwrite && mapped;
  assign wr_ok = psel && penable && pwrite && mapped && seen_reg;

  // Sizes follow the live size field
  assign tx_cap = fpr_pkg::tx_data_words(size_reg);
  assign rx_cap = fpr_pkg::rx_data_words(size_reg);
  assign rx_scap = fpr_pkg::rx_stat_words(size_reg);
  assign mac_ctrl = mac_reg;

  // Read mux; levels show the host receive FIFO only, never the MAC-side ones
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (paddr)
      fpr_pkg::OFS_MAC_CTRL: rd_val = mac_reg;
      fpr_pkg::OFS_ERR_STAT: begin
        rd_val[fpr_pkg::ES_TX_ERR] = txerr_reg;
        rd_val[fpr_pkg::ES_RX_ERR] = rxerr_reg;
        rd_val[fpr_pkg::ES_DROP_LO +: 16] = drop_reg;
      end
      fpr_pkg::OFS_LEVELS: begin
        rd_val[15:0] = {1'b0, rx_used_reg, 2'b00};
        rd_val[23:16] = rx_sc_reg[7:0];
      end
      fpr_pkg::OFS_HARDWARE_CONFIG: begin
        rd_val[fpr_pkg::HC_SOFT_RST] = st_reg == fpr_pkg::SR_WAIT;
        rd_val[fpr_pkg::HC_SOFT_TO] = to_reg;
        rd_val[fpr_pkg::HC_SIZE_LO +: 4] = size_reg;
        rd_val[fpr_pkg::HC_MBO] = mbo_reg;
        rd_val[fpr_pkg::HC_KEEP_LO +: 2] = keep_reg;
      end
      fpr_pkg::OFS_RX_PATH: rd_val[fpr_pkg::RP_SKIP] = skip_reg;
      default: rd_val = 32'h0000_0000;
    endcase
    // Captured in the setup cycle so prdata is a flop in the access cycle
    prdata_next = (psel && !penable) ? rd_val : prdata;
  end

  // Control registers and the soft reset sequencer
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    mac_next = mac_reg;
    size_next = size_reg;
    keep_next = keep_reg;
    mbo_next = mbo_reg;
    to_next = to_reg;
    seen_next = seen_reg;
    txerr_next = txerr_reg;
    rxerr_next = rxerr_reg;
    skip_next = skip_reg;
    drop_next = drop_reg;
    sreset = 1'b0;
    unique case (st_reg)
      fpr_pkg::SR_IDLE: begin
        cnt_next = '0;
        if (wr_ok && paddr == fpr_pkg::OFS_HARDWARE_CONFIG &&
            pwdata[fpr_pkg::HC_SOFT_RST]) begin
          st_next = fpr_pkg::SR_WAIT;
          to_next = 1'b0;
        end
      end
      fpr_pkg::SR_WAIT: begin
        cnt_next = cnt_reg + 9'd1;
        // Resetting with the PHY clocks stopped would wedge the MAC
        if (phy_sync_reg) begin
          sreset = 1'b1;
          st_next = fpr_pkg::SR_IDLE;
        end else if (cnt_reg == fpr_pkg::SOFT_CNT_LAST) begin
          to_next = 1'b1;
          st_next = fpr_pkg::SR_IDLE;
        end
      end
      default: st_next = fpr_pkg::SR_IDLE;
    endcase
    if (wr_ok && paddr == fpr_pkg::OFS_MAC_CTRL) begin
      mac_next = pwdata;
    end
    if (wr_ok && paddr == fpr_pkg::OFS_HARDWARE_CONFIG) begin
      size_next = pwdata[fpr_pkg::HC_SIZE_LO +: 4];
      mbo_next = pwdata[fpr_pkg::HC_MBO];
      keep_next = pwdata[fpr_pkg::HC_KEEP_LO +: 2];
    end
    if (skip_reg && rx_head_end) begin
      skip_next = 1'b0;
    end
    if (rd_acc) begin
      seen_next = 1'b1;
    end
    if (sreset) begin
      mac_next = fpr_pkg::MAC_CTRL_RST;
      size_next = fpr_pkg::SIZE_RST;
      mbo_next = 1'b0;
      skip_next = 1'b0;
      drop_next = '0;
      txerr_next = 1'b0;
      rxerr_next = 1'b0;
    end
    if (sreset || pm_wake) begin
      seen_next = 1'b0;
    end
    // Events after the clears: an error or drop in the clearing cycle survives; a skip write is blocked by sreset
    if (wr_ok && paddr == fpr_pkg::OFS_RX_PATH &&
        pwdata[fpr_pkg::RP_SKIP] && !sreset) begin
      skip_next = 1'b1;
    end
    if (tx_err_ev) begin
      txerr_next = 1'b1;
    end
    if (rx_err_ev) begin
      rxerr_next = 1'b1;
    end
    if (drop_pulse) begin
      drop_next = drop_next + 16'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= fpr_pkg::SR_IDLE;
      cnt_reg <= '0;
      mac_reg <= fpr_pkg::MAC_CTRL_RST;
      size_reg <= fpr_pkg::SIZE_RST;
      keep_reg <= '0;
      mbo_reg <= 1'b0;
      to_reg <= 1'b0;
      seen_reg <= 1'b0;
      txerr_reg <= 1'b0;
      rxerr_reg <= 1'b0;
      skip_reg <= 1'b0;
      drop_reg <= '0;
      prdata <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      mac_reg <= mac_next;
      size_reg <= size_next;
      keep_reg <= keep_next;
      mbo_reg <= mbo_next;
      to_reg <= to_next;
      seen_reg <= seen_next;
      txerr_reg <= txerr_next;
      rxerr_reg <= rxerr_next;
      skip_reg <= skip_next;
      drop_reg <= drop_next;
      prdata <= prdata_next;
    end
  end

  // Transmit data FIFO: only complete frames move to the MAC side
  assign tx_push = host_tx_push && tx_used_reg < tx_cap &&
                   tx_fc_reg != 8'(fpr_pkg::TX_LEN_DEPTH);
  assign tx_err_ev = host_tx_push && !tx_push;
  assign tx_move = tx_fc_reg != 8'd0 && mil_tx_rdy;
  assign tx_mv_last = tx_cons_reg + 12'd1 == tx_len_mem[tx_ri_reg];

  // Receive data FIFO, full four words early
  assign rx_full = rx_used_reg + fpr_pkg::RX_FULL_MARGIN >= rx_cap;
  assign rx_room = !rx_full && {4'h0, rx_sc_reg} < rx_scap;
  assign rx_in = mil_rx_valid && rx_room;
  // Skip owns the read side; host pops meanwhile are ignored
  assign rx_take = (skip_reg || host_rx_pop) && rx_sc_reg != 9'd0;
  assign rx_err_ev = host_rx_pop && !skip_reg && rx_sc_reg == 9'd0;
  assign rx_head_end = rx_take &&
                       rx_cons_reg + 12'd1 == rx_len_mem[rx_ri_reg];
  assign rx_frame_ready = rx_sc_reg != 9'd0;

  // Frame length memories
  always_ff @(posedge pclk) begin
    if (tx_push && host_tx_last) begin
      tx_len_mem[tx_wi_reg] <= tx_wlen_reg + 12'd1;
    end
    if (rx_in && mil_rx_last) begin
      rx_len_mem[rx_wi_reg] <= rx_cur_reg + 12'd1;
    end
  end

  // Occupancy and frame bookkeeping for both host FIFOs
  always_comb begin
    tx_used_next = tx_used_reg + 13'(tx_push) - 13'(tx_move);
    tx_wlen_next = tx_push ? (host_tx_last ? '0 : tx_wlen_reg + 12'd1)
                           : tx_wlen_reg;
    tx_wi_next = tx_wi_reg + 7'(tx_push && host_tx_last);
    tx_cons_next = tx_move ? (tx_mv_last ? '0 : tx_cons_reg + 12'd1)
                           : tx_cons_reg;
    tx_ri_next = tx_ri_reg + 7'(tx_move && tx_mv_last);
    tx_fc_next = tx_fc_reg + 8'(tx_push && host_tx_last)
                 - 8'(tx_move && tx_mv_last);
    rx_used_next = rx_used_reg + 13'(rx_in) - 13'(rx_take);
    rx_cur_next = rx_in ? (mil_rx_last ? '0 : rx_cur_reg + 12'd1)
                        : rx_cur_reg;
    rx_wi_next = rx_wi_reg + 8'(rx_in && mil_rx_last);
    rx_cons_next = rx_take ? (rx_head_end ? '0 : rx_cons_reg + 12'd1)
                           : rx_cons_reg;
    rx_ri_next = rx_ri_reg + 8'(rx_head_end);
    rx_sc_next = rx_sc_reg + 9'(rx_in && mil_rx_last) - 9'(rx_head_end);
    if (sreset) begin
      tx_used_next = '0;
      tx_wlen_next = '0;
      tx_wi_next = '0;
      tx_cons_next = '0;
      tx_ri_next = '0;
      tx_fc_next = '0;
      rx_used_next = '0;
      rx_cur_next = '0;
      rx_wi_next = '0;
      rx_cons_next = '0;
      rx_ri_next = '0;
      rx_sc_next = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_used_reg <= '0;
      tx_wlen_reg <= '0;
      tx_wi_reg <= '0;
      tx_cons_reg <= '0;
      tx_ri_reg <= '0;
      tx_fc_reg <= '0;
      rx_used_reg <= '0;
      rx_cur_reg <= '0;
      rx_wi_reg <= '0;
      rx_cons_reg <= '0;
      rx_ri_reg <= '0;
      rx_sc_reg <= '0;
    end else begin
      tx_used_reg <= tx_used_next;
      tx_wlen_reg <= tx_wlen_next;
      tx_wi_reg <= tx_wi_next;
      tx_cons_reg <= tx_cons_next;
      tx_ri_reg <= tx_ri_next;
      tx_fc_reg <= tx_fc_next;
      rx_used_reg <= rx_used_next;
      rx_cur_reg <= rx_cur_next;
      rx_wi_reg <= rx_wi_next;
      rx_cons_reg <= rx_cons_next;
      rx_ri_reg <= rx_ri_next;
      rx_sc_reg <= rx_sc_next;
    end
  end

  // MAC-side buffers of fixed size
  fpr_mil_tx u_mil_tx (
    .clk(pclk),
    .rst_n(presetn),
    .clr(sreset),
    .in_valid(tx_fc_reg != 8'd0),
    .in_last(tx_mv_last),
    .in_ready(mil_tx_rdy),
    .mac_take(mac_tx_take),
    .out_valid(mac_tx_valid),
    .out_last(mac_tx_last)
  );

  fpr_mil_rx u_mil_rx (
    .clk(pclk),
    .rst_n(presetn),
    .clr(sreset),
    .enable(mac_reg[fpr_pkg::MC_RX_EN]),
    .in_valid(mac_rx_valid),
    .in_last(mac_rx_last),
    .out_ready(rx_room),
    .out_valid(mil_rx_valid),
    .out_last(mil_rx_last),
    .drop_pulse(drop_pulse)
  );

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_soft_req;
    wr_ok && paddr == fpr_pkg::OFS_HARDWARE_CONFIG && pwdata[fpr_pkg::HC_SOFT_RST] &&
    st_reg == fpr_pkg::SR_IDLE;
  endsequence
  // Worst case is the whole 400-cycle wait plus the step back to idle
  sequence s_soft_end;
    ##[1:401] st_reg == fpr_pkg::SR_IDLE;
  endsequence

  a_soft_self_clear: assert property (s_soft_req |-> s_soft_end)
    else $error("Soft reset trigger did not clear");
  a_soft_mac_dflt: assert property (sreset |=>
    mac_reg == fpr_pkg::MAC_CTRL_RST)
    else $error("MAC control not restored by soft reset");
  a_soft_keep_bits: assert property (sreset |=>
    size_reg == fpr_pkg::SIZE_RST && keep_reg == $past(keep_reg))
    else $error("System register soft reset wrong");
  a_soft_err_clr: assert property (sreset && !tx_err_ev &&
    !rx_err_ev |=> !txerr_reg && !rxerr_reg)
    else $error("Error flags survived soft reset");
  a_write_gated: assert property (!seen_reg |=>
    mac_reg == $past(mac_reg) || $past(sreset))
    else $error("Write took effect before first read");
  // Checks the resulting level, not the acceptance term itself
  a_rx_full_early: assert property (
    rx_used_reg + fpr_pkg::RX_FULL_MARGIN <= rx_cap)
    else $error("Receive data filled inside margin");
  a_drop_count: assert property (drop_pulse && !sreset
    |=> drop_reg == $past(drop_reg) + 16'd1)
    else $error("Dropped frame not counted");
  a_skip_holds: assert property (skip_reg && !rx_head_end &&
    !sreset |=> skip_reg)
    else $error("Skip bit cleared early");
  a_soft_timeout: assert property (
    (st_reg == fpr_pkg::SR_WAIT && !phy_sync_reg) [*8] |->
    ##[0:400] (to_reg || sreset))
    else $error("Soft reset timeout not flagged");
endmodule

// [verification/fpr_host_model.sv]
// Host model: APB master issuing one register transfer at a time
`timescale 1ns/10ps
module fpr_host_model (
  input logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr
);
  logic hung = 1'b0; // Set when a slave never answers
  // Idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // Request held until pready seen high or 32 edges pass; a spare edge avoids reusing it
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 32);
    hung = hung | (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

// [verification/fpr_fifo_ctrl_tb.sv]
// Self-checking bench for the FIFO partition and receive skip block
`timescale 1ns/10ps
module fpr_fifo_ctrl_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, mac_ctrl, rd;
  logic phy_ok = 1'b1;
  logic tx_push = 1'b0, tx_last = 1'b0, rx_pop = 1'b0, pm_wake = 1'b0;
  logic rx_v = 1'b0, rx_l = 1'b0, tx_take = 1'b0, tx_v, tx_l, rx_rdy;
  int fail_count = 0;
  int n_tests = 0;
  typedef struct {logic [7:0] a; logic [31:0] d, m, x;} fpr_row_s;
  // Address, write data, read mask, expected masked read
  fpr_row_s rows [4] = '{
    '{fpr_pkg::OFS_MAC_CTRL, 32'h0000_0001, 32'h0000_0001, 32'h0000_0001},
    '{fpr_pkg::OFS_HARDWARE_CONFIG, 32'h0012_0000, 32'h001F_0000, 32'h0012_0000},
    '{fpr_pkg::OFS_HARDWARE_CONFIG, 32'h001E_0000, 32'h001F_0000, 32'h001E_0000},
    '{fpr_pkg::OFS_HARDWARE_CONFIG, 32'h3018_0000, 32'h300F_0000, 32'h3008_0000}};
  fpr_host_model host_u (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  fpr_fifo_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phy_clk_ok(phy_ok), .pm_wake(pm_wake), .host_tx_push(tx_push),
    .host_tx_last(tx_last), .host_rx_pop(rx_pop), .mac_rx_valid(rx_v),
    .mac_rx_last(rx_l), .mac_tx_take(tx_take), .mac_tx_valid(tx_v),
    .mac_tx_last(tx_l), .rx_frame_ready(rx_rdy), .mac_ctrl(mac_ctrl));
  // 25 ns clock
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  task automatic wrap_up();
    if (fail_count == 0 && n_tests > 0 && !host_u.hung)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, rd, err);
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, x);
    host_u.xfer(1'b0, a, 32'h0000_0000, rd, err);
    chk(rd & m, x);
  endtask
  // Poll the trigger bit; a bound keeps a stuck reset from hanging
  task automatic soft_wait();
    for (int k = 0; k < 200; k++) begin
      host_u.xfer(1'b0, fpr_pkg::OFS_HARDWARE_CONFIG, 32'h0000_0000, rd, err);
      if (rd[0] === 1'b0) return;
    end
    fail_count++;
    wrap_up();
  endtask
  // Back-to-back word strobes, last flagged on the final word
  task automatic frame(input logic tx, input int n);
    for (int i = 0; i < n; i++) begin
      tx_push <= tx;
      tx_last <= tx && i == n - 1;
      rx_v <= !tx;
      rx_l <= !tx && i == n - 1;
      @(posedge pclk);
    end
    {tx_push, tx_last, rx_v, rx_l} <= 4'h0;
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wr(fpr_pkg::OFS_MAC_CTRL, 32'h0000_0001);
    rdm(fpr_pkg::OFS_MAC_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    rdm(fpr_pkg::OFS_HARDWARE_CONFIG, 32'h001F_0003, 32'h0005_0000);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdm(rows[i].a, rows[i].m, rows[i].x);
    end
    host_u.xfer(1'b0, 8'h90, 32'h0000_0000, rd, err);
    chk({rd[31:1], err}, 32'h0000_0001);
    // Receive disabled: frame dropped and counted; empty pop flags error
    wr(fpr_pkg::OFS_MAC_CTRL, 32'h0000_0000);
    frame(1'b0, 2);
    rx_pop <= 1'b1;
    @(posedge pclk);
    rx_pop <= 1'b0;
    rdm(fpr_pkg::OFS_ERR_STAT, 32'hFFFF_0003, 32'h0001_0002);
    wr(fpr_pkg::OFS_MAC_CTRL, 32'h0000_0001);
    wr(fpr_pkg::OFS_HARDWARE_CONFIG, 32'h3018_0001);
    soft_wait();
    rdm(fpr_pkg::OFS_HARDWARE_CONFIG, 32'h301F_0003, 32'h3005_0000);
    chk(mac_ctrl, fpr_pkg::MAC_CTRL_RST);
    rdm(fpr_pkg::OFS_ERR_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
    // PHY clocks stopped: soft reset gives up and flags a timeout
    phy_ok <= 1'b0;
    wr(fpr_pkg::OFS_HARDWARE_CONFIG, 32'h0005_0001);
    soft_wait();
    rdm(fpr_pkg::OFS_HARDWARE_CONFIG, 32'h0000_0003, 32'h0000_0002);
    phy_ok <= 1'b1;
    wr(fpr_pkg::OFS_MAC_CTRL, 32'h0000_0001);
    frame(1'b0, 3);
    repeat (8) @(posedge pclk);
    chk({31'h0, rx_rdy}, 32'h0000_0001);
    rdm(fpr_pkg::OFS_LEVELS, 32'h0000_FFFF, 32'h0000_000C);
    wr(fpr_pkg::OFS_RX_PATH, 32'h8000_0000);
    repeat (8) @(posedge pclk);
    rdm(fpr_pkg::OFS_RX_PATH, 32'h8000_0000, 32'h0000_0000);
    rdm(fpr_pkg::OFS_LEVELS, 32'h0000_FFFF, 32'h0000_0000);
    chk({31'h0, rx_rdy}, 32'h0000_0000);
    frame(1'b1, 2);
    repeat (6) @(posedge pclk);
    chk({30'h0, tx_v, tx_l}, 32'h0000_0002);
    tx_take <= 1'b1;
    @(posedge pclk);
    tx_take <= 1'b0;
    @(posedge pclk);
    chk({30'h0, tx_v, tx_l}, 32'h0000_0003);
    tx_take <= 1'b1;
    @(posedge pclk);
    tx_take <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({31'h0, tx_v}, 32'h0000_0000);
    // Wake from power saving re-arms the first-read gate
    pm_wake <= 1'b1;
    @(posedge pclk);
    pm_wake <= 1'b0;
    wr(fpr_pkg::OFS_MAC_CTRL, 32'h0000_0000);
    chk(mac_ctrl, 32'h0000_0001);
    rdm(fpr_pkg::OFS_MAC_CTRL, 32'hFFFF_FFFF, 32'h0000_0001);
    wr(fpr_pkg::OFS_MAC_CTRL, 32'h0000_0000);
    chk(mac_ctrl, 32'h0000_0000);
    wrap_up();
  end
endmodule
